// [design/pmc_power_mgmt_config_regs.sv]
// power management configuration registers and quadlet byte-lane swap
//
// Function
// - swap bit set byte-reverses every PCI quadlet
// - swap bit loaded from serial ROM
// - control bits 31..1 read zero, ignore writes
// - capability code reads 01h
// - link pointer reads 00h, last entry
// - wake-state mask defaults to 1100b
// - wake-from-D2 follows misc bit 13
// - State_two_flag follows misc bit 10
// - wake-from-cold follows misc bit 15
// - State_one_flag bit reads zero
// - power report bit reads zero
// - bits 7 and 6 read zero
// - special initialisation bit reads zero
// - auxiliary source bit reads zero
// - wake clock need bit reads zero
// - revision field reads 001b
// - misc register loaded from serial ROM
// - capabilities pointer reads 44h
// - power level field sets device state
`timescale 1ns/1ns
module pmc_power_mgmt_config_regs #(
  parameter int DATA_WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cfgRead,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgAck,
  input wire logic romLoad,
  input wire logic [31:0] romControlWord,
  input wire logic [31:0] romMiscWord,
  output logic swapEnable,
  output logic [1:0] devicePowerLevel,
  input wire logic [DATA_WIDTH-1:0] busRxData,
  output logic [DATA_WIDTH-1:0] localRxData,
  input wire logic [DATA_WIDTH-1:0] localTxData,
  output logic [DATA_WIDTH-1:0] busTxData
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [5:0] dwordAddr;
  logic ctrlWrite;
  logic csrWrite;
  logic miscWrite;
  logic readTaken;
  logic [31:0] ctrlValue;
  logic [31:0] csrValue;
  logic [31:0] miscValue;
  logic [15:0] capHeader;
  logic [15:0] pmCaps;
  logic [31:0] next_cfgRdData;

  assign dwordAddr = cfgAddr[7:2];
  // a write takes priority; a read in the same cycle is dropped
  assign readTaken = cfgRead & ~cfgWrite;
  assign ctrlWrite = cfgWrite & (dwordAddr == pmc_pkg::CTRL_DWORD);
  assign csrWrite = cfgWrite & (dwordAddr == pmc_pkg::CSR_DWORD);
  assign miscWrite = cfgWrite & (dwordAddr == pmc_pkg::MISC_DWORD);

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  pmc_cfg_field #(
    .WIDTH(32),
    .WRITE_MASK(pmc_pkg::CTRL_MASK),
    .RESET_VALUE(pmc_pkg::CTRL_RESET)
  ) ctrlReg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeStrobe(ctrlWrite),
    .byteEn(cfgByteEn),
    .writeData(cfgWrData),
    .loadStrobe(romLoad),
    .loadData(romControlWord),
    .value(ctrlValue)
  );

  pmc_cfg_field #(
    .WIDTH(32),
    .WRITE_MASK(pmc_pkg::MISC_MASK),
    .RESET_VALUE(pmc_pkg::MISC_RESET)
  ) miscReg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeStrobe(miscWrite),
    .byteEn(cfgByteEn),
    .writeData(cfgWrData),
    .loadStrobe(romLoad),
    .loadData(romMiscWord),
    .value(miscValue)
  );

  pmc_cfg_field #(
    .WIDTH(32),
    .WRITE_MASK(pmc_pkg::CSR_MASK),
    .RESET_VALUE(pmc_pkg::CSR_RESET)
  ) csrReg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .writeStrobe(csrWrite),
    .byteEn(cfgByteEn),
    .writeData(cfgWrData),
    .loadStrobe(1'b0),
    .loadData(32'h0000_0000),
    .value(csrValue)
  );

  assign swapEnable = ctrlValue[pmc_pkg::SWAP_BIT];
  assign devicePowerLevel = csrValue[1:0];

  // ----------------------------------------------------------------
  // capability words
  // ----------------------------------------------------------------
  assign capHeader = {pmc_pkg::LINK_PTR, pmc_pkg::CAP_CODE};

  always_comb
  begin
    pmCaps = 16'h0000;
    pmCaps[pmc_pkg::CAP_COLD_BIT] = miscValue[pmc_pkg::MISC_COLD_BIT];
    pmCaps[pmc_pkg::CAP_D3HOT_BIT] = 1'b1;
    pmCaps[pmc_pkg::CAP_D2WAKE_BIT] = miscValue[pmc_pkg::MISC_D2WAKE_BIT];
    pmCaps[pmc_pkg::CAP_D2SUP_BIT] = miscValue[pmc_pkg::MISC_D2SUP_BIT];
    pmCaps[2:0] = pmc_pkg::PM_REVISION;
  end

  // ----------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------
  always_comb
  begin
    case (dwordAddr)
      pmc_pkg::CAP_PTR_DWORD:
        next_cfgRdData = {24'h00_0000, pmc_pkg::CAP_PTR_VALUE};
      pmc_pkg::CTRL_DWORD:
        next_cfgRdData = ctrlValue;
      pmc_pkg::CAP_DWORD:
        next_cfgRdData = {pmCaps, capHeader};
      pmc_pkg::CSR_DWORD:
        next_cfgRdData = csrValue;
      pmc_pkg::MISC_DWORD:
        next_cfgRdData = miscValue;
      default:
        next_cfgRdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfgRdData <= 32'h0000_0000;
    else if (readTaken)
      cfgRdData <= next_cfgRdData;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfgAck <= 1'b0;
    else
      cfgAck <= cfgRead | cfgWrite;
  end

  // ----------------------------------------------------------------
  // quadlet byte-lane swap in both directions
  // ----------------------------------------------------------------
  pmc_byte_swap #(
    .WIDTH(DATA_WIDTH)
  ) rxSwap (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .swapEnable(swapEnable),
    .inData(busRxData),
    .outData(localRxData)
  );

  pmc_byte_swap #(
    .WIDTH(DATA_WIDTH)
  ) txSwap (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .swapEnable(swapEnable),
    .inData(localTxData),
    .outData(busTxData)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic capRead;
  logic pastValid;

  assign capRead = readTaken & (dwordAddr == pmc_pkg::CAP_DWORD);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pastValid <= 1'b0;
    else
      pastValid <= 1'b1;
  end

  tx_swap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pastValid && $past(swapEnable)) |->
    (busTxData[31:0] == pmc_pkg::swap_bytes($past(localTxData[31:0]))))
    else $error("outbound quadlet not byte swapped");

  rx_swap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pastValid && $past(swapEnable)) |->
    (localRxData[31:0] == pmc_pkg::swap_bytes($past(busRxData[31:0]))))
    else $error("inbound quadlet not byte swapped");

  tx_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pastValid && !$past(swapEnable)) |-> (busTxData == $past(localTxData)))
    else $error("outbound quadlet altered with swap off");

  rx_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pastValid && !$past(swapEnable)) |-> (localRxData == $past(busRxData)))
    else $error("inbound quadlet altered with swap off");

  rd_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !readTaken |=> $stable(cfgRdData))
    else $error("read data changed without a read");

  power_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !csrWrite |=> $stable(devicePowerLevel))
    else $error("power level changed without a write");

  rom_swap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    romLoad |=> (swapEnable == $past(romControlWord[0])))
    else $error("swap bit not taken from rom word");

  ctrl_upper_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (readTaken && dwordAddr == pmc_pkg::CTRL_DWORD) |=> (cfgRdData[31:1] == 31'h0))
    else $error("control upper bits not zero");

  cap_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[7:0] == 8'h01))
    else $error("capability code wrong");

  link_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[15:8] == 8'h00))
    else $error("link pointer not zero");

  wake_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[30] && cfgRdData[28:27] == 2'b00))
    else $error("wake state mask fixed bits wrong");

  wake_d2_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[29] == $past(miscValue[13])))
    else $error("wake from d2 does not follow misc");

  state_two_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[26] == $past(miscValue[10])))
    else $error("state_two_flag does not follow misc");

  wake_cold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[31] == $past(miscValue[15])))
    else $error("wake from cold does not follow misc");

  fixed_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[25:19] == 7'h00))
    else $error("fixed zero capability bits set");

  revision_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capRead |=> (cfgRdData[18:16] == 3'b001))
    else $error("revision field wrong");

  rom_misc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    romLoad |=> (miscValue == ($past(romMiscWord) & 32'h0000_A400)))
    else $error("misc register not loaded from rom");

  cap_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (readTaken && dwordAddr == pmc_pkg::CAP_PTR_DWORD) |=> (cfgRdData == 32'h0000_0044))
    else $error("capabilities pointer wrong");

  power_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (csrWrite && cfgByteEn[0]) |=> (devicePowerLevel == $past(cfgWrData[1:0])))
    else $error("power level not entered");

  lane_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (csrWrite && !cfgByteEn[0]) |=> $stable(devicePowerLevel))
    else $error("disabled byte lane was written");

  ack_timing_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgRead || cfgWrite) |=> cfgAck ##1 (cfgAck == ($past(cfgRead) || $past(cfgWrite))))
    else $error("access answer timing wrong");

endmodule

// [design/pmc_pkg.sv]
// constants and helpers for the power management configuration slice
package pmc_pkg;

  // ----------------------------------------------------------------
  // configuration offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
  localparam logic [7:0] CTRL_OFFSET = 8'h40;
  localparam logic [7:0] CAP_HDR_OFFSET = 8'h44;
  localparam logic [7:0] PM_CAPS_OFFSET = 8'h46;
  localparam logic [7:0] PM_CSR_OFFSET = 8'h48;
  localparam logic [7:0] MISC_OFFSET = 8'hF0;
  localparam logic [5:0] CAP_PTR_DWORD = CAP_PTR_OFFSET[7:2];
  localparam logic [5:0] CTRL_DWORD = CTRL_OFFSET[7:2];
  localparam logic [5:0] CAP_DWORD = CAP_HDR_OFFSET[7:2];
  localparam logic [5:0] CSR_DWORD = PM_CSR_OFFSET[7:2];
  localparam logic [5:0] MISC_DWORD = MISC_OFFSET[7:2];
  // capabilities word sits in the upper half of its dword
  localparam int CAPS_SHIFT = 16;

  // ----------------------------------------------------------------
  // fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_PTR_VALUE = 8'h44;
  localparam logic [7:0] CAP_CODE = 8'h01;
  localparam logic [7:0] LINK_PTR = 8'h00;
  localparam logic [2:0] PM_REVISION = 3'h1;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam logic [31:0] MISC_RESET = 32'h0000_2400;
  localparam logic [31:0] MISC_MASK = 32'h0000_A400;
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [31:0] CSR_MASK = 32'h0000_0003;
  localparam logic [15:0] CAPS_RESET = 16'h6401;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SWAP_BIT = 0;
  localparam int MISC_COLD_BIT = 15;
  localparam int MISC_D2WAKE_BIT = 13;
  localparam int MISC_D2SUP_BIT = 10;
  localparam int CAP_COLD_BIT = 15;
  localparam int CAP_D3HOT_BIT = 14;
  localparam int CAP_D2WAKE_BIT = 13;
  localparam int CAP_D1WAKE_BIT = 12;
  localparam int CAP_D0WAKE_BIT = 11;
  localparam int CAP_D2SUP_BIT = 10;
  localparam int CAP_D1SUP_BIT = 9;
  localparam int CAP_REPORT_BIT = 8;
  localparam int CAP_INIT_BIT = 5;
  localparam int CAP_STANDBY_BIT = 4;
  localparam int CAP_CLOCK_BIT = 3;

  // ----------------------------------------------------------------
  // power level encoding and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] POWER_D0 = 2'h0;
  localparam logic [1:0] POWER_D1 = 2'h1;
  localparam logic [1:0] POWER_D2 = 2'h2;
  localparam logic [1:0] POWER_D3 = 2'h3;
  localparam int ACK_CYCLES = 1;

  function automatic logic [31:0] swap_bytes(input logic [31:0] d);
    swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

endpackage

// [design/pmc_cfg_field.sv]
// one configuration register with writable mask, byte enables and load port
`timescale 1ns/1ns
module pmc_cfg_field #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] WRITE_MASK = '0,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic writeStrobe,
  input wire logic [WIDTH/8-1:0] byteEn,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic loadStrobe,
  input wire logic [WIDTH-1:0] loadData,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] laneMask;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      laneMask[i] = byteEn[i/8] & WRITE_MASK[i];
    end
  end

  // load wins over a host write in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      value <= RESET_VALUE;
    else if (loadStrobe)
      value <= (loadData & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    else if (writeStrobe)
      value <= (value & ~laneMask) | (writeData & laneMask);
  end

endmodule

// [design/pmc_byte_swap.sv]
// registered quadlet path with optional byte reversal
`timescale 1ns/1ns
module pmc_byte_swap #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic swapEnable,
  input wire logic [WIDTH-1:0] inData,
  output logic [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] swapped;

  always_comb
  begin
    for (int i = 0; i < WIDTH / 8; i++)
    begin
      swapped[i*8 +: 8] = inData[(WIDTH/8 - 1 - i)*8 +: 8];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      outData <= '0;
    else
      outData <= swapEnable ? swapped : inData;
  end

endmodule

// [tb/pmc_host_model.sv]
// host bridge model issuing configuration read and write cycles
`timescale 1ns/1ns
module pmc_host_model (
  input wire logic sys_clk,
  output logic cfgRead,
  output logic cfgWrite,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgAck
);
  initial
  begin
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'hFF;
    cfgByteEn = 4'hF;
    cfgWrData = 32'hFFFF_FFFF;
  end

  // one request cycle, answer sampled in the cycle after; idle lines show inverse values
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(negedge sys_clk);
    cfgRead = !wr;
    cfgWrite = wr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(negedge sys_clk);
    ok = (cfgAck === 1'b1);
    q = cfgRdData;
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = ~a;
    cfgByteEn = ~be;
    cfgWrData = ~d;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the power management configuration slice
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfgRead, cfgWrite, cfgAck, swapEnable;
  logic romLoad = 1'b0;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [1:0] devicePowerLevel;
  logic [31:0] cfgWrData, cfgRdData, localRxData, busTxData;
  logic [31:0] romControlWord = 32'h0000_0000;
  logic [31:0] romMiscWord = 32'h0000_0000;
  logic [31:0] busRxData = 32'h0000_0000;
  logic [31:0] localTxData = 32'h0000_0000;
  logic [31:0] seed = 32'h0001_2237;
  logic [31:0] mCtrl, mMisc, r, d;
  logic [1:0] mPwr;
  logic [7:0] addrs [8] = '{8'h34, 8'h40, 8'h44, 8'h46, 8'h48, 8'hF0, 8'h80, 8'h4A};
  int fail_count = 0;
  int num_checks = 0;

  always #5 sys_clk = ~sys_clk;

  pmc_power_mgmt_config_regs #(.DATA_WIDTH(32)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgAck(cfgAck), .romLoad(romLoad),
    .romControlWord(romControlWord), .romMiscWord(romMiscWord), .swapEnable(swapEnable),
    .devicePowerLevel(devicePowerLevel), .busRxData(busRxData), .localRxData(localRxData),
    .localTxData(localTxData), .busTxData(busTxData));

  pmc_host_model host (.sys_clk(sys_clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgAck(cfgAck));

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] rev(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [31:0] expRd(input logic [7:0] a);
    logic [15:0] caps;
    caps = 16'h4001 | (mMisc[15:0] & 16'hA400);
    case (a[7:2])
      6'h0D: return 32'h0000_0044;
      6'h10: return mCtrl;
      6'h11: return {caps, 16'h0001};
      6'h12: return {30'h0, mPwr};
      6'h3C: return mMisc;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic rnd(output logic [31:0] v);
    seed = lfsr(seed);
    v = seed;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic [31:0] q;
    logic ok;
    host.xfer(1'b0, a, 4'h0, 32'h0000_0000, q, ok);
    chk("read ack", 32'h0000_0001, {31'h0, ok});
    chk("read data", expRd(a), q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    logic [31:0] q, m;
    logic ok;
    host.xfer(1'b1, a, be, v, q, ok);
    chk("write ack", 32'h0000_0001, {31'h0, ok});
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    case (a[7:2])
      6'h10: mCtrl = (mCtrl & ~(m & 32'h0000_0001)) | (v & m & 32'h0000_0001);
      6'h12: mPwr = be[0] ? v[1:0] : mPwr;
      6'h3C: mMisc = (mMisc & ~(m & 32'h0000_A400)) | (v & m & 32'h0000_A400);
      default: ;
    endcase
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    mCtrl = 32'h0000_0000;
    mMisc = 32'h0000_2400;
    mPwr = 2'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    chk("swap reset", mCtrl, {31'h0, swapEnable});
    foreach (addrs[i]) rd(addrs[i]);
    $display("test reset_values done");
    for (int i = 0; i < 24; i++)
    begin
      rnd(r);
      rnd(d);
      wr(addrs[r[2:0]], r[7:4], d);
      chk("swap bit", mCtrl, {31'h0, swapEnable});
      rd(addrs[r[2:0]]);
      rd(8'h44);
    end
    $display("test byte_enable_writes done");
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h48, 4'h1, p);
      chk("power level", {30'h0, mPwr}, {30'h0, devicePowerLevel});
      rd(8'h48);
    end
    $display("test power_levels done");
    for (int i = 0; i < 6; i++)
    begin
      rnd(r);
      rnd(d);
      @(negedge sys_clk);
      romLoad = 1'b1;
      romControlWord = r;
      romMiscWord = d;
      @(negedge sys_clk);
      romLoad = 1'b0;
      mCtrl = r & 32'h0000_0001;
      mMisc = d & 32'h0000_A400;
      chk("rom swap", mCtrl, {31'h0, swapEnable});
      rd(8'h44);
      rd(8'hF0);
    end
    $display("test rom_load done");
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h40, 4'h1, s);
      for (int i = 0; i < 6; i++)
      begin
        rnd(r);
        rnd(d);
        @(negedge sys_clk);
        busRxData = r;
        localTxData = d;
        @(negedge sys_clk);
        chk("rx quadlet", mCtrl[0] ? rev(r) : r, localRxData);
        chk("tx quadlet", mCtrl[0] ? rev(d) : d, busTxData);
      end
    end
    $display("test quadlet_swap done");
    // reset in mid-run must clear every output register
    @(negedge sys_clk);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    chk("reset rx", 32'h0000_0000, localRxData);
    chk("reset tx", 32'h0000_0000, busTxData);
    chk("reset read data", 32'h0000_0000, cfgRdData);
    chk("reset ack", 32'h0000_0000, {31'h0, cfgAck});
    chk("reset level", 32'h0000_0000, {30'h0, devicePowerLevel});
    chk("reset swap", 32'h0000_0000, {31'h0, swapEnable});
    sys_rst = 1'b0;
    mCtrl = 32'h0000_0000;
    mMisc = 32'h0000_2400;
    mPwr = 2'h0;
    rd(8'h44);
    rd(8'h48);
    $display("test mid_reset done");
    results();
  end
endmodule
